// ===== hdl/ptd_dialer.sv
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "ptd_defs.svh"
// Summary of operation
// - First mode code inverts mode from default
// - Second mode code restores default mode
// - Mode pin changes default and current mode
// - Valid key is one row plus column
// - Low input starts alternate row/column scanning
// - 32 ms debounce, store if still valid
// - On-hook: no scan, store, never signal
// - Key during redial holds at pause, discarded
// - Binary mode: rows are code, column1 strobes
// - Codes map to digits then special functions
// - Input choice latched at power-up or on-hook
// - Ack pin high selects binary, low keypad
// - 500 Hz ack tone, max 30 ms or release
// - Ack every key in pulse, redial in tone
// - Tone mode mute active through whole dialing
// - Hook transition reinitialises, mode to default
// - Hook flash break on loop break output
// - Tone: mute, 100 ms, 98 ms bursts, 102 gaps
// - Pause code inserts 1.1 s plus pauses
// - 28 entry buffer, replayed by redial key
// - Flash gives 600 ms break, not redialed
// - Mode pin high tone, low pulse default
module ptd_dialer import ptd_pkg::*; #(
	parameter int CYC_PER_MS = `PTD_CLK_HZ / `PTD_MS_PER_S,
	parameter int BUF_DEPTH = `PTD_BUF_DEPTH
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hook_state_input,
	input wire logic default_mode_select,
	input wire logic [3:0] keypad_row_in,
	output logic [3:0] keypad_row_out,
	output logic [3:0] keypad_row_oe,
	input wire logic [3:0] keypad_col_in,
	output logic [3:0] keypad_col_out,
	output logic [3:0] keypad_col_oe,
	input wire logic ack_tone_in,
	output logic ack_tone_out,
	output logic ack_tone_oe,
	output logic line_mute_output_out,
	output logic line_mute_output_oe,
	output logic loop_break_out,
	output logic loop_break_oe,
	output logic dtmf_tone_active,
	output logic [3:0] dtmf_tone_code
);
	initial begin
		if (CYC_PER_MS < 2 || BUF_DEPTH < 2 || BUF_DEPTH > 31) $error("ptd_dialer bad parameter");
	end
	// ==========================================================================
	// Input synchronisers
	logic [10:0] sync1_reg, sync2_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= 11'h7ff;
			sync2_reg <= 11'h7ff;
		end else begin
			sync1_reg <= {ack_tone_in, default_mode_select, hook_state_input, keypad_col_in,
				keypad_row_in};
			sync2_reg <= sync1_reg;
		end
	end
	wire logic [3:0] row_s = sync2_reg[3:0];
	wire logic [3:0] col_s = sync2_reg[7:4];
	wire logic hook_s = sync2_reg[8];
	wire logic dflt_s = sync2_reg[9];
	wire logic strap_s = sync2_reg[10];
	// ==========================================================================
	// Millisecond tick
	logic [31:0] pre_reg;
	wire logic ms_tick = (pre_reg == 32'(CYC_PER_MS - 1));
	logic hook_d_reg, bin_mode_reg, toggle_reg, strobe_d_reg;
	logic [1:0] strap_wait_reg;
	wire logic hook_edge = hook_s ^ hook_d_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_reg <= 32'h0;
			hook_d_reg <= 1'b1;
			strap_wait_reg <= 2'h3;
			bin_mode_reg <= 1'b0;
			strobe_d_reg <= 1'b0;
		end else begin
			pre_reg <= ms_tick ? 32'h0 : pre_reg + 32'h1;
			hook_d_reg <= hook_s;
			strobe_d_reg <= col_s[0];
			// Strap is latched once the synchronisers hold real pin levels
			if (strap_wait_reg != 2'h0)
				strap_wait_reg <= strap_wait_reg - 2'h1;
			if ((strap_wait_reg == 2'h1) || ((strap_wait_reg == 2'h0) && hook_s))
				bin_mode_reg <= strap_s;
		end
	end
	// Current mode: 1 is tone, 0 is pulse
	wire logic cur_mode = dflt_s ^ toggle_reg;
	// ==========================================================================
	// Keypad scan
	logic phase_reg, row_ok_reg, col_ok_reg;
	logic [1:0] row_idx_reg, col_idx_reg;
	logic [1:0] scan_ms_reg;
	ptd_key_type kstate_reg;
	logic [5:0] key_ms_reg;
	ptd_entry_type held_reg;
	function automatic logic one_hot(input logic [3:0] v);
		return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
	endfunction
	function automatic logic [1:0] enc(input logic [3:0] v);
		return v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
	endfunction
	function automatic logic [3:0] key_code(input logic [1:0] r, input logic [1:0] c);
		logic [3:0] t [0:15];
		t = '{4'h1, 4'h2, 4'h3, `PTD_CODE_FLASH, 4'h4, 4'h5, 4'h6, `PTD_CODE_MODE,
			4'h7, 4'h8, 4'h9, `PTD_CODE_PAUSE, `PTD_CODE_STAR, 4'h0, `PTD_CODE_HASH,
			`PTD_CODE_REDIAL};
		return t[{r, c}];
	endfunction
	wire logic keypad_mode = !bin_mode_reg;
	wire logic scanning = keypad_mode && !hook_s;
	wire logic [3:0] row_low = ~row_s;
	wire logic [3:0] col_low = ~col_s;
	wire logic key_valid = row_ok_reg && col_ok_reg;
	wire logic scan_busy = (kstate_reg != PTD_K_IDLE) || (|row_low) || row_ok_reg || col_ok_reg;
	wire logic phase_flip = scanning && ms_tick && scan_busy &&
		(scan_ms_reg == 2'(`PTD_SCAN_HALF_MS - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= 1'b0;
			scan_ms_reg <= 2'h0;
			row_ok_reg <= 1'b0;
			col_ok_reg <= 1'b0;
			row_idx_reg <= 2'h0;
			col_idx_reg <= 2'h0;
		end else if (!keypad_mode || hook_edge) begin
			phase_reg <= 1'b0;
			row_ok_reg <= 1'b0;
			col_ok_reg <= 1'b0;
		end else if (hook_s) begin
			row_ok_reg <= one_hot(row_low);
			col_ok_reg <= one_hot(col_low);
			row_idx_reg <= enc(row_low);
			col_idx_reg <= enc(col_low);
		end else begin
			if (ms_tick && scan_busy)
				scan_ms_reg <= phase_flip ? 2'h0 : scan_ms_reg + 2'h1;
			if (phase_flip) begin
				phase_reg <= !phase_reg;
				if (!phase_reg) begin
					row_ok_reg <= one_hot(row_low);
					row_idx_reg <= enc(row_low);
				end else begin
					col_ok_reg <= one_hot(col_low);
					col_idx_reg <= enc(col_low);
				end
			end
		end
	end
	// Phase 0 drives columns low and reads rows; phase 1 the reverse
	assign keypad_col_out = 4'h0;
	assign keypad_row_out = 4'h0;
	assign keypad_col_oe = {4{scanning && !phase_reg}};
	assign keypad_row_oe = {4{scanning && phase_reg}};
	// ==========================================================================
	// Key acceptance and acknowledge tone
	logic replay_reg;
	logic [4:0] ack_ms_reg;
	logic ack_on_reg, ack_wave_reg;
	wire logic [3:0] cur_key = key_code(row_idx_reg, col_idx_reg);
	wire logic deb_done = (kstate_reg == PTD_K_DEB) && ms_tick && (key_ms_reg == 6'h0);
	wire logic key_accept = deb_done && key_valid && (cur_key == held_reg.code);
	wire logic strobe_rise = bin_mode_reg && col_s[0] && !strobe_d_reg;
	wire ptd_entry_type new_entry = strobe_rise ? '{1'b1, {row_s[3], row_s[2], row_s[1], row_s[0]}}
		: '{key_accept, cur_key};
	wire logic entry_redial = new_entry.valid && (new_entry.code == `PTD_CODE_REDIAL);
	wire logic entry_store = new_entry.valid && !entry_redial && !replay_reg;
	wire logic ack_start = key_accept && !replay_reg && (!cur_mode || entry_redial);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kstate_reg <= PTD_K_IDLE;
			key_ms_reg <= 6'h0;
			held_reg <= '0;
		end else if (hook_edge || !keypad_mode) begin
			kstate_reg <= PTD_K_IDLE;
		end else begin
			unique case (kstate_reg)
				PTD_K_IDLE: if (key_valid) begin
					kstate_reg <= PTD_K_DEB;
					key_ms_reg <= 6'(`PTD_DEBOUNCE_MS);
					held_reg <= '{1'b1, cur_key};
				end
				PTD_K_DEB: if (deb_done) begin
					kstate_reg <= key_accept ? PTD_K_HELD : PTD_K_IDLE;
				end else if (ms_tick) begin
					key_ms_reg <= key_ms_reg - 6'h1;
				end
				PTD_K_HELD: if (!key_valid) kstate_reg <= PTD_K_IDLE;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_on_reg <= 1'b0;
			ack_ms_reg <= 5'h0;
			ack_wave_reg <= 1'b0;
		end else if (ack_start) begin
			ack_on_reg <= 1'b1;
			ack_ms_reg <= 5'h0;
			ack_wave_reg <= 1'b1;
		end else if (ack_on_reg && (!key_valid || hook_edge ||
			(ms_tick && ack_ms_reg == 5'(`PTD_ACK_MAX_MS - 1)))) begin
			ack_on_reg <= 1'b0;
		end else if (ack_on_reg && ms_tick) begin
			ack_ms_reg <= ack_ms_reg + 5'h1;
			ack_wave_reg <= !ack_wave_reg;
		end
	end
	assign ack_tone_out = ack_wave_reg;
	assign ack_tone_oe = ack_on_reg && keypad_mode;
	// ==========================================================================
	// Redial buffer
	logic [3:0] mem [0:BUF_DEPTH-1];
	logic [4:0] count_reg, rd_ptr_reg;
	logic fresh_reg;
	logic [3:0] last_reg;
	ptd_dial_type dial_reg;
	logic inhibit_reg;
	wire logic replay_hold_w = replay_reg && (kstate_reg != PTD_K_IDLE || key_valid);
	wire logic fetch = (dial_reg == PTD_FETCH) && !replay_hold_w;
	wire logic have_entry = rd_ptr_reg != count_reg;
	wire logic start_redial = entry_redial && !replay_reg && !hook_s && (dial_reg == PTD_IDLE);
	wire logic [3:0] fetch_code = mem[rd_ptr_reg];
	always_ff @(posedge pclk) begin
		if (entry_store && (fresh_reg || count_reg < 5'(BUF_DEPTH)))
			mem[fresh_reg ? 5'h0 : count_reg] <= new_entry.code;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 5'h0;
			rd_ptr_reg <= 5'h0;
			fresh_reg <= 1'b1;
			replay_reg <= 1'b0;
			last_reg <= 4'h0;
		end else if (hook_edge) begin
			fresh_reg <= 1'b1;
			replay_reg <= 1'b0;
			rd_ptr_reg <= count_reg;
		end else begin
			if (entry_store && (fresh_reg || count_reg < 5'(BUF_DEPTH))) begin
				count_reg <= fresh_reg ? 5'h1 : count_reg + 5'h1;
				last_reg <= new_entry.code;
				fresh_reg <= 1'b0;
				if (fresh_reg)
					rd_ptr_reg <= hook_s ? 5'h1 : 5'h0;
			end else if (start_redial) begin
				rd_ptr_reg <= 5'h0;
				replay_reg <= 1'b1;
				fresh_reg <= 1'b0;
			end else if (fetch) begin
				if (have_entry)
					rd_ptr_reg <= rd_ptr_reg + 5'h1;
				else
					replay_reg <= 1'b0;
			end
		end
	end
	// ==========================================================================
	// Signalling engine
	logic [10:0] dial_ms_reg;
	logic [3:0] pulses_reg;
	wire logic dial_done = ms_tick && (dial_ms_reg == 11'h0);
	wire logic [10:0] idp_ms = cur_mode ? 11'(`PTD_TONE_OFF_MS) : 11'(`PTD_IDP_MS);
	wire logic is_digit = fetch_code < `PTD_CODE_MODE;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dial_reg <= PTD_IDLE;
			dial_ms_reg <= 11'h0;
			pulses_reg <= 4'h0;
			toggle_reg <= 1'b0;
			dtmf_tone_code <= 4'h0;
		end else if (hook_edge || hook_s) begin
			dial_reg <= PTD_IDLE;
			toggle_reg <= 1'b0;
		end else begin
			if (ms_tick && dial_ms_reg != 11'h0)
				dial_ms_reg <= dial_ms_reg - 11'h1;
			unique case (dial_reg)
				PTD_IDLE: if ((have_entry || start_redial) && !inhibit_reg) begin
					dial_reg <= PTD_PRE;
					dial_ms_reg <= cur_mode ? 11'(`PTD_PSD_MS) : 11'(`PTD_PDP_MS);
				end
				PTD_PRE: if (dial_done) dial_reg <= PTD_FETCH;
				PTD_FETCH: if (fetch) begin
					if (!have_entry) begin
						dial_reg <= PTD_IDLE;
					end else if (is_digit && cur_mode) begin
						dial_reg <= PTD_TONE_ON;
						dtmf_tone_code <= fetch_code;
						dial_ms_reg <= 11'(`PTD_TONE_ON_MS);
					end else if (is_digit && fetch_code <= 4'h9) begin
						dial_reg <= PTD_BRK;
						pulses_reg <= (fetch_code == 4'h0) ? 4'ha : fetch_code;
						dial_ms_reg <= 11'(`PTD_BREAK_MS);
					end else if (fetch_code == `PTD_CODE_MODE || fetch_code == `PTD_CODE_PAUSE) begin
						toggle_reg <= toggle_reg ^ (fetch_code == `PTD_CODE_MODE);
						dial_reg <= PTD_SPEC_A;
						dial_ms_reg <= idp_ms;
					end else if (fetch_code == `PTD_CODE_FLASH && !replay_reg) begin
						dial_reg <= PTD_FLASH;
						dial_ms_reg <= 11'(`PTD_FLASH_MS);
					end
				end
				PTD_TONE_ON: if (dial_done) begin
					dial_reg <= PTD_TONE_OFF;
					dial_ms_reg <= 11'(`PTD_TONE_OFF_MS);
				end
				PTD_TONE_OFF: if (dial_done) dial_reg <= PTD_FETCH;
				PTD_BRK: if (dial_done) begin
					dial_reg <= PTD_MAKE;
					pulses_reg <= pulses_reg - 4'h1;
					dial_ms_reg <= 11'(`PTD_MAKE_MS);
				end
				PTD_MAKE: if (dial_done) begin
					dial_reg <= (pulses_reg == 4'h0) ? PTD_IDP : PTD_BRK;
					dial_ms_reg <= (pulses_reg == 4'h0) ? idp_ms : 11'(`PTD_BREAK_MS);
				end
				PTD_IDP: if (dial_done) dial_reg <= PTD_FETCH;
				PTD_SPEC_A: if (dial_done) begin
					dial_reg <= PTD_SPEC_B;
					dial_ms_reg <= 11'(`PTD_PAUSE_MS);
				end
				PTD_SPEC_B: if (dial_done) begin
					dial_reg <= PTD_IDP;
					dial_ms_reg <= idp_ms;
				end
				PTD_FLASH: if (dial_done) begin
					dial_reg <= PTD_IDP;
					dial_ms_reg <= idp_ms;
				end
				default: dial_reg <= PTD_IDLE;
			endcase
		end
	end
	assign line_mute_output_out = 1'b0;
	assign line_mute_output_oe = (dial_reg != PTD_IDLE);
	assign loop_break_out = 1'b0;
	assign loop_break_oe = (dial_reg == PTD_BRK) || (dial_reg == PTD_FLASH);
	assign dtmf_tone_active = (dial_reg == PTD_TONE_ON);
	// ==========================================================================
	// APB registers
	logic [31:0] rdata_reg;
	wire logic setup = psel && !penable;
	wire logic wr_en = psel && penable && pwrite;
	wire logic hit_status = (paddr == `PTD_ADDR_STATUS);
	wire logic hit_ctrl = (paddr == `PTD_ADDR_CTRL);
	wire logic hit_last = (paddr == `PTD_ADDR_LAST);
	wire logic hit_any = hit_status || hit_ctrl || hit_last;
	wire logic [31:0] status_w = {11'h0, rd_ptr_reg, 3'h0, count_reg, dial_reg, replay_reg,
		bin_mode_reg, dflt_s, cur_mode};
	wire logic [31:0] rd_mux = hit_status ? status_w : hit_ctrl ? {31'h0, inhibit_reg} :
		hit_last ? {28'h0, last_reg} : 32'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= 32'h0;
			inhibit_reg <= 1'(`PTD_CTRL_RESET);
		end else begin
			if (setup)
				rdata_reg <= pwrite ? 32'h0 : rd_mux;
			if (wr_en && hit_ctrl)
				inhibit_reg <= pwdata[`PTD_CTRL_INHIBIT];
		end
	end
	assign prdata = rdata_reg;
	assign pready = penable;
	assign pslverr = psel && penable && !hit_any;
	// ==========================================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_hook_edge;
		hook_edge;
	endsequence
	a_mode_default: assert property (s_hook_edge |=> !toggle_reg && (dial_reg == PTD_IDLE))
		else $error("hook edge did not restore default");
	a_mode_toggle: assert property (fetch && have_entry && fetch_code == `PTD_CODE_MODE && !hook_s
		&& !hook_edge |=> toggle_reg != $past(toggle_reg))
		else $error("mode code did not toggle");
	a_mute_dialing: assert property (dial_reg != PTD_IDLE |-> line_mute_output_oe)
		else $error("mute released during dialing");
	a_buffer_limit: assert property (count_reg <= 5'(BUF_DEPTH))
		else $error("buffer overflow");
	a_binary_hiz: assert property (bin_mode_reg |-> keypad_row_oe == 4'h0
		&& keypad_col_oe == 4'h0)
		else $error("keypad driven in binary mode");
	a_onhook_noscan: assert property (hook_s |-> !scanning && !phase_flip)
		else $error("scan while on-hook");
	a_ack_bound: assert property (ack_on_reg |-> ack_ms_reg < 5'(`PTD_ACK_MAX_MS))
		else $error("ack tone too long");
	a_tone_burst: assert property (dtmf_tone_active |-> dial_ms_reg <= 11'(`PTD_TONE_ON_MS))
		else $error("tone burst too long");
	a_flash_break: assert property (dial_reg == PTD_FLASH |-> loop_break_oe && !replay_reg)
		else $error("flash without break");
	a_debounce_store: assert property (entry_store && !bin_mode_reg |->
		kstate_reg == PTD_K_DEB)
		else $error("keypad store without debounce");
endmodule // ptd_dialer

// ===== hdl/ptd_defs.svh
`ifndef PTD_DEFS_SVH
`define PTD_DEFS_SVH
// ==========================================================================
// Clock and time base
`define PTD_CLK_HZ 10000000
`define PTD_MS_PER_S 1000
// ==========================================================================
// Times in milliseconds
`define PTD_DEBOUNCE_MS 32
`define PTD_SCAN_HALF_MS 2
`define PTD_ACK_MAX_MS 30
`define PTD_ACK_HALF_MS 1
`define PTD_BREAK_MS 60
`define PTD_MAKE_MS 40
`define PTD_PDP_MS 140
`define PTD_IDP_MS 940
`define PTD_PSD_MS 100
`define PTD_TONE_ON_MS 98
`define PTD_TONE_OFF_MS 102
`define PTD_PAUSE_MS 1100
`define PTD_FLASH_MS 600
// ==========================================================================
// Buffer and codes
`define PTD_BUF_DEPTH 28
`define PTD_CODE_STAR 4'ha
`define PTD_CODE_HASH 4'hb
`define PTD_CODE_MODE 4'hc
`define PTD_CODE_PAUSE 4'hd
`define PTD_CODE_FLASH 4'he
`define PTD_CODE_REDIAL 4'hf
// ==========================================================================
// Register map
`define PTD_ADDR_STATUS 12'h000
`define PTD_ADDR_CTRL 12'h004
`define PTD_ADDR_LAST 12'h008
`define PTD_CTRL_INHIBIT 0
`define PTD_CTRL_RESET 32'h00000000
`endif

// ===== hdl/ptd_pkg.sv
package ptd_pkg;
	// ==========================================================================
	// Types
	typedef enum logic [3:0] {
		PTD_IDLE = 4'h0, PTD_PRE = 4'h1, PTD_FETCH = 4'h3, PTD_TONE_ON = 4'h2,
		PTD_TONE_OFF = 4'h6, PTD_BRK = 4'h7, PTD_MAKE = 4'h5, PTD_IDP = 4'h4,
		PTD_SPEC_A = 4'hc, PTD_SPEC_B = 4'hd, PTD_FLASH = 4'hf
	} ptd_dial_type;
	typedef enum logic [1:0] {PTD_K_IDLE = 2'h0, PTD_K_DEB = 2'h1, PTD_K_HELD = 2'h3} ptd_key_type;
	typedef struct packed {
		logic valid;
		logic [3:0] code;
	} ptd_entry_type;
endpackage

// ===== sim/ptd_far_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Keypad, binary port and strap at the far side
module ptd_far_model (
	input wire logic bin_sel,
	input wire logic key_down,
	input wire logic [1:0] key_row,
	input wire logic [1:0] key_col,
	input wire logic [3:0] bin_code,
	input wire logic bin_strobe,
	input wire logic [3:0] row_oe,
	input wire logic [3:0] col_oe,
	input wire logic ack_out,
	input wire logic ack_oe,
	output logic [3:0] row_in,
	output logic [3:0] col_in,
	output logic ack_in
);
	logic [3:0] row_hit;
	logic [3:0] col_hit;
	// Single contact joins one row to one column, pull-ups elsewhere
	assign row_hit = (key_down && col_oe[key_col]) ? (4'h1 << key_row) : 4'h0;
	assign col_hit = (key_down && row_oe[key_row]) ? (4'h1 << key_col) : 4'h0;
	// Code held on the rows while the strobe is high
	assign row_in = bin_sel ? bin_code : ~(row_oe | row_hit);
	assign col_in = bin_sel ? {3'h7, bin_strobe} : ~(col_oe | col_hit);
	// Strap through a resistor, overridden while the pin drives
	assign ack_in = ack_oe ? ack_out : bin_sel;
endmodule // ptd_far_model

// ===== sim/ptd_dialer_tb_top.sv
`timescale 1ns/1ps
`include "ptd_defs.svh"
module ptd_dialer_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic hook, mode_pin, ack_in, ack_out, ack_oe, mute_out, mute_oe, brk_out, brk_oe;
	logic tone_act, bin_sel, key_down, bin_strobe;
	logic [1:0] key_row, key_col;
	logic [3:0] row_in, row_out, row_oe, col_in, col_out, col_oe, tone_code, bin_code;
	int n_errors = 0;
	int tests_run = 0;
	int n;
	// ==========================================================================
	// Design and far side
	ptd_dialer #(.CYC_PER_MS(10), .BUF_DEPTH(28)) ptd_dialer_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .hook_state_input(hook),
		.default_mode_select(mode_pin), .keypad_row_in(row_in), .keypad_row_out(row_out),
		.keypad_row_oe(row_oe), .keypad_col_in(col_in), .keypad_col_out(col_out),
		.keypad_col_oe(col_oe), .ack_tone_in(ack_in), .ack_tone_out(ack_out),
		.ack_tone_oe(ack_oe), .line_mute_output_out(mute_out), .line_mute_output_oe(mute_oe),
		.loop_break_out(brk_out), .loop_break_oe(brk_oe), .dtmf_tone_active(tone_act),
		.dtmf_tone_code(tone_code));
	ptd_far_model ptd_far_model_i (.bin_sel(bin_sel), .key_down(key_down), .key_row(key_row),
		.key_col(key_col), .bin_code(bin_code), .bin_strobe(bin_strobe), .row_oe(row_oe),
		.col_oe(col_oe), .ack_out(ack_out), .ack_oe(ack_oe), .row_in(row_in),
		.col_in(col_in), .ack_in(ack_in));
	// ==========================================================================
	// Shared tasks
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic sig(input int i);
		case (i)
			0: return mute_oe;
			1: return brk_oe;
			2: return tone_act;
			3: return ack_oe;
			default: return ack_out & ack_oe;
		endcase
	endfunction
	task automatic wait_sig(input int i, input logic v, input int lim);
		n = 0;
		while (sig(i) !== v && n < lim) begin
			@(negedge pclk);
			n++;
		end
	endtask
	task automatic count_rise(input int i, input int lim);
		logic prev;
		prev = sig(i);
		n = 0;
		repeat (lim) begin
			@(negedge pclk);
			if (sig(i) === 1'b1 && prev !== 1'b1) n++;
			prev = sig(i);
		end
	endtask
	task automatic press(input logic [1:0] r, input logic [1:0] c, input logic d);
		@(posedge pclk);
		key_row <= r;
		key_col <= c;
		key_down <= d;
	endtask
	task automatic strobe(input logic [3:0] c);
		@(posedge pclk);
		bin_code <= c;
		repeat (30) @(posedge pclk);
		bin_strobe <= 1'b1;
		repeat (30) @(posedge pclk);
		bin_strobe <= 1'b0;
		@(posedge pclk);
		bin_code <= ~c;
		repeat (90) @(posedge pclk);
	endtask
	task automatic report_and_stop;
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ==========================================================================
	// Scenarios
	task automatic t_regs;
		chk("mute_oe_idle", 32'h0, mute_oe);
		chk("break_oe_idle", 32'h0, brk_oe);
		apb(1'b0, `PTD_ADDR_STATUS, 32'h0);
		chk("status_mode", 32'h3, rd & 32'h7);
		apb(1'b1, `PTD_ADDR_CTRL, 32'h1);
		apb(1'b0, `PTD_ADDR_CTRL, 32'h0);
		chk("ctrl_readback", 32'h1, rd);
		apb(1'b1, `PTD_ADDR_CTRL, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk("unmapped_err", 32'h1, err);
		chk("unmapped_data", 32'h0, rd);
	endtask
	task automatic t_tone_key;
		press(2'h1, 2'h1, 1'b1);
		wait_sig(0, 1'b1, 600);
		chk("debounce_store", 32'h1, n >= 320 && n <= 400);
		count_rise(3, 300);
		chk("ack_in_tone", 32'h0, n);
		wait_sig(2, 1'b1, 1000);
		chk("pre_signal", 32'h1, n >= 698 && n <= 712);
		chk("tone_code", 32'h5, tone_code);
		wait_sig(2, 1'b0, 1100);
		chk("burst_len", 32'h1, n >= 978 && n <= 992);
		press(2'h1, 2'h1, 1'b0);
		wait_sig(0, 1'b0, 1100);
		chk("mute_to_end", 32'h1, n >= 1013 && n <= 1035);
	endtask
	task automatic t_pulse;
		@(posedge pclk);
		mode_pin <= 1'b0;
		repeat (10) @(posedge pclk);
		apb(1'b0, `PTD_ADDR_STATUS, 32'h0);
		chk("mode_pin_low", 32'h0, rd & 32'h3);
		press(2'h0, 2'h2, 1'b1);
		wait_sig(3, 1'b1, 600);
		chk("ack_start", 32'h1, n >= 320 && n <= 400);
		count_rise(4, 300);
		chk("ack_cycles", 32'h1, n >= 13 && n <= 16);
		wait_sig(3, 1'b0, 30);
		chk("ack_stop", 32'h1, n <= 5);
		press(2'h0, 2'h2, 1'b0);
		count_rise(1, 5000);
		chk("pulse_breaks", 32'h3, n);
	endtask
	task automatic t_binary;
		@(posedge pclk);
		mode_pin <= 1'b1;
		hook <= 1'b1;
		bin_sel <= 1'b1;
		repeat (20) @(posedge pclk);
		for (int c = 0; c < 16; c++) begin
			strobe(c[3:0]);
			apb(1'b0, `PTD_ADDR_LAST, 32'h0);
			chk("last_code", (c == 15) ? 32'he : 32'(c), rd & 32'hf);
			chk("mute_on_hook", 32'h0, mute_oe);
		end
		apb(1'b0, `PTD_ADDR_STATUS, 32'h0);
		chk("binary_latched", 32'h7, rd & 32'h7);
		chk("keypad_oe", 32'h0, {row_oe, col_oe});
		@(posedge pclk);
		hook <= 1'b0;
		repeat (20) @(posedge pclk);
		apb(1'b0, `PTD_ADDR_STATUS, 32'h0);
		chk("mode_after_hook", 32'h7, rd & 32'h7);
		strobe(4'hc);
		strobe(4'h2);
		count_rise(1, 25000);
		chk("breaks_toggled", 32'h2, n);
		apb(1'b0, `PTD_ADDR_STATUS, 32'h0);
		chk("mode_toggled", 32'h0, rd & 32'h1);
		strobe(4'hc);
		strobe(4'h2);
		count_rise(2, 40000);
		chk("burst_restored", 32'h1, n);
		chk("restored_code", 32'h2, tone_code);
	endtask
	// ==========================================================================
	// Main sequence and watchdog
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		hook = 1'b0;
		mode_pin = 1'b1;
		key_down = 1'b0;
		key_row = 2'h0;
		key_col = 2'h0;
		bin_sel = 1'b0;
		bin_code = 4'h0;
		bin_strobe = 1'b0;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_tone_key;
		t_pulse;
		t_binary;
		report_and_stop;
	end
	initial begin
		repeat (100000) @(posedge pclk);
		n_errors++;
		report_and_stop;
	end
endmodule // ptd_dialer_tb_top
